// ==== hw/cbr_pkg.sv ====
package cbr_pkg;

    // Bus widths of the debug register segment port
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 3;
    localparam int ROM_IDX_W = 4;
    localparam int ROM_DEPTH = 16;

    // Segment offsets
    localparam logic [15:0] OFS_IBCC = 16'h1120;
    localparam logic [15:0] OFS_IBPC = 16'h1128;
    localparam logic [15:0] OFS_DBCC = 16'h2128;
    localparam logic [15:0] OFS_DBPC = 16'h2130;
    localparam logic [15:0] OFS_CAPTURE = 16'h2ff0;
    localparam logic [15:0] OFS_CBCTL = 16'h8000;
    localparam logic [15:0] OFS_PRIME_I = 16'h8300;
    localparam logic [15:0] OFS_PRIME_D = 16'h84e0;
    localparam logic [15:0] OFS_SWCTL = 16'h8900;
    localparam logic [15:0] OFS_SWCNT = 16'h8908;

    // Strides of the per-breakpoint register groups
    localparam logic [15:0] STRIDE_BRK = 16'h0100;
    localparam logic [15:0] STRIDE_PRIME = 16'h0020;

    // Complex break control register layout
    localparam int CTL_MODE_BIT = 8;
    localparam int CTL_FEAT_W = 5;
    localparam logic CTL_MODE_RST = 1'b1;
    // Stopwatch, priming, data qualify, tuple, pass counter flags
    localparam logic [CTL_FEAT_W-1:0] CTL_FEATURES = 5'h1f;

    // Stopwatch control preset: pair0 stop channel 4, all else zero
    localparam logic [31:0] SWCTL_PRESET = 32'h0000_0080;

    // Priming condition presets, slots 0-7 instruction, 8-15 data
    localparam logic [31:0] PRIME_8I4D [0:ROM_DEPTH-1] = '{
        32'h1211_2000, 32'h1210_2000, 32'h1413_2100, 32'h1412_2100,
        32'h1615_2200, 32'h1614_2200, 32'h1017_2300, 32'h1016_2300,
        32'h2111_1000, 32'h2213_1200, 32'h2315_1400, 32'h2017_1600,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000
    };
    localparam logic [31:0] PRIME_6I2D [0:ROM_DEPTH-1] = '{
        32'h1211_2000, 32'h1210_2000, 32'h1110_2000, 32'h1514_2100,
        32'h1513_2100, 32'h1413_2100, 32'h0000_0000, 32'h0000_0000,
        32'h1211_1000, 32'h1514_1300, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000
    };

    // Register access request
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } cbr_req_t;

    // Selects for the per-breakpoint registers served outside
    typedef struct packed {
        logic instCtl;
        logic instPass;
        logic dataCtl;
        logic dataPass;
        logic [IDX_W-1:0] index;
    } cbr_ext_t;

    // Source of a pending read
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_CAPTURE,
        SRC_CTL,
        SRC_PRIME,
        SRC_SWCTL
    } cbr_src_t;

endpackage

// ==== hw/cbr_capture_reg.sv ====
`timescale 1ns/10ps
`default_nettype none
module cbr_capture_reg #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // No reset on purpose: content is undefined until the first capture
    always_ff @(posedge clk)
    begin
        if (load)
        begin
            q <= d;
        end
    end

    // Captured value is the load data of the break
    property p_cap_take;
        @(posedge clk) disable iff (rst)
        load |=> (q == $past(d));
    endproperty
    a_cap_take: assert property (p_cap_take)
        else $error("capture register missed load data");

    // Value holds until the next precise load break
    property p_cap_hold;
        @(posedge clk) disable iff (rst)
        (!load && !$past(load)) |=> $stable(q);
    endproperty
    a_cap_hold: assert property (p_cap_hold)
        else $error("capture register changed without a break");

endmodule
`default_nettype wire

// ==== hw/cbr_prime_rom.sv ====
`timescale 1ns/10ps
`default_nettype none
module cbr_prime_rom #(
    parameter bit WIDE_CFG = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rdEn,
    input wire logic [cbr_pkg::ROM_IDX_W-1:0] index,
    output logic [cbr_pkg::DATA_W-1:0] rdata
);
    import cbr_pkg::*;

    // Table choice follows the breakpoint configuration
    wire logic [DATA_W-1:0] entry;
    assign entry = WIDE_CFG ? PRIME_8I4D[index] : PRIME_6I2D[index];

    // Registered read port; contents never change
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= '0;
        end
        else if (rdEn)
        begin
            rdata <= entry;
        end
    end

    // Condition 0 is always bypass
    property p_rom_cond0;
        @(posedge clk) disable iff (rst)
        rdEn |=> (rdata[7:0] == 8'h00);
    endproperty
    a_rom_cond0: assert property (p_rom_cond0)
        else $error("priming condition 0 not bypass");

    // Bytes 3 to 1: top bits zero, no reserved trigger type
    property p_rom_bytes;
        @(posedge clk) disable iff (rst)
        rdEn |=> (rdata[31:30] == 2'h0 && rdata[23:22] == 2'h0 &&
            rdata[15:14] == 2'h0 && rdata[29:28] != 2'h3 &&
            rdata[21:20] != 2'h3 && rdata[13:12] != 2'h3);
    endproperty
    a_rom_bytes: assert property (p_rom_bytes)
        else $error("priming condition byte malformed");

endmodule
`default_nettype wire

// ==== hw/cbr_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - A load taking a precise data value break has its data captured.
// - The capture register is one 32-bit read-only field, undefined at reset.
// - Per-breakpoint registers decode at a 0x100 stride, priming at 0x20.
// - Control bit 8 is the writable stopwatch mode, reset to one.
// - Mode zero lets the stopwatch run free, one lets triggers run it.
// - Control bits 4 and 3 read one: stopwatch and priming present.
// - Control bits 2, 1, 0 read one: qualify, tuple, pass counters.
// - All complex features come together and the control exists only then.
// - Priming registers are read-only fixed presets of trigger wiring.
// - Four priming conditions per breakpoint, only register A exists.
// - Priming registers hold four bytes, condition 3 top to 0 bottom.
// - Each byte has two zero bits, a trigger type and a break number.
// - Condition 0 always means bypass and reads as zero.
// - The stopwatch control register is read-only.
module cbr_regs #(
    parameter int NUM_IBRK = 8,
    parameter int NUM_DBRK = 4,
    parameter bit COMPLEX_BRK = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire cbr_pkg::cbr_req_t req,
    input wire logic loadBrkTaken,
    input wire logic [cbr_pkg::DATA_W-1:0] loadData,
    output cbr_pkg::cbr_ext_t extSel,
    output logic [cbr_pkg::DATA_W-1:0] rdata,
    output logic rdValid,
    output logic stopwatchMode
);
    import cbr_pkg::*;

    // Offset lies on a slot boundary inside the implemented range
    function automatic logic slotHit(
        input logic [15:0] off,
        input logic [15:0] stride,
        input int n
    );
        slotHit = (off % stride == 16'h0000) && (off / stride < 16'(n));
    endfunction

    // Slot number of an offset
    function automatic logic [IDX_W-1:0] slotIdx(
        input logic [15:0] off,
        input logic [15:0] stride
    );
        logic [15:0] q;
        q = off / stride;
        slotIdx = q[IDX_W-1:0];
    endfunction

    wire logic isRead;
    wire logic isWrite;
    wire logic [15:0] ibccOff;
    wire logic [15:0] ibpcOff;
    wire logic [15:0] dbccOff;
    wire logic [15:0] dbpcOff;
    wire logic [15:0] primeIOff;
    wire logic [15:0] primeDOff;
    wire logic hitIbcc;
    wire logic hitIbpc;
    wire logic hitDbcc;
    wire logic hitDbpc;
    wire logic [IDX_W-1:0] extIdx;
    wire logic hitPrimeI;
    wire logic hitPrimeD;
    wire logic hitCapture;
    wire logic hitCtl;
    wire logic hitSwCtl;
    wire cbr_src_t reqSrc;
    wire logic romRd;
    wire logic [ROM_IDX_W-1:0] romIndex;
    wire logic [DATA_W-1:0] romData;
    wire logic capLoad;
    wire logic [DATA_W-1:0] capValue;
    wire logic [DATA_W-1:0] ctlValue;
    wire logic ctlWrite;
    wire logic [DATA_W-1:0] next_rdata;
    logic rdPend;
    cbr_src_t rdSrc;

    // Request qualifiers
    assign isRead = req.valid && !req.write;
    assign isWrite = req.valid && req.write;

    // Distances from each register group base; wrap makes low addresses miss
    assign ibccOff = req.addr - OFS_IBCC;
    assign ibpcOff = req.addr - OFS_IBPC;
    assign dbccOff = req.addr - OFS_DBCC;
    assign dbpcOff = req.addr - OFS_DBPC;
    assign primeIOff = req.addr - OFS_PRIME_I;
    assign primeDOff = req.addr - OFS_PRIME_D;

    // Per-breakpoint control and pass counters are served by the match logic
    assign hitIbcc = COMPLEX_BRK && req.valid &&
        slotHit(ibccOff, STRIDE_BRK, NUM_IBRK);
    assign hitIbpc = COMPLEX_BRK && req.valid &&
        slotHit(ibpcOff, STRIDE_BRK, NUM_IBRK);
    assign hitDbcc = COMPLEX_BRK && req.valid &&
        slotHit(dbccOff, STRIDE_BRK, NUM_DBRK);
    assign hitDbpc = COMPLEX_BRK && req.valid &&
        slotHit(dbpcOff, STRIDE_BRK, NUM_DBRK);
    assign extIdx = hitIbcc ? slotIdx(ibccOff, STRIDE_BRK) :
        hitIbpc ? slotIdx(ibpcOff, STRIDE_BRK) :
        hitDbcc ? slotIdx(dbccOff, STRIDE_BRK) :
        hitDbpc ? slotIdx(dbpcOff, STRIDE_BRK) : '0;
    assign extSel = {hitIbcc, hitIbpc, hitDbcc, hitDbpc, extIdx};

    // Local registers; complex registers vanish without complex break
    assign hitPrimeI = COMPLEX_BRK &&
        slotHit(primeIOff, STRIDE_PRIME, NUM_IBRK);
    assign hitPrimeD = COMPLEX_BRK &&
        slotHit(primeDOff, STRIDE_PRIME, NUM_DBRK);
    assign hitCapture = (NUM_DBRK > 0) && (req.addr == OFS_CAPTURE);
    assign hitCtl = COMPLEX_BRK && (req.addr == OFS_CBCTL);
    assign hitSwCtl = COMPLEX_BRK && (req.addr == OFS_SWCTL);

    // Read source; anything else answers zero
    assign reqSrc = hitCapture ? SRC_CAPTURE :
        hitCtl ? SRC_CTL :
        (hitPrimeI || hitPrimeD) ? SRC_PRIME :
        hitSwCtl ? SRC_SWCTL : SRC_NONE;

    // Priming preset lookup, data breakpoints in the upper half
    assign romRd = isRead && (hitPrimeI || hitPrimeD);
    assign romIndex = hitPrimeD ?
        {1'b1, slotIdx(primeDOff, STRIDE_PRIME)} :
        {1'b0, slotIdx(primeIOff, STRIDE_PRIME)};

    cbr_prime_rom #(
        .WIDE_CFG(NUM_IBRK > 6)
    ) u_prime (
        .clk(clk),
        .rst(rst),
        .rdEn(romRd),
        .index(romIndex),
        .rdata(romData)
    );

    // Only a precise load break updates the capture; bus writes cannot
    assign capLoad = loadBrkTaken && (NUM_DBRK > 0);

    cbr_capture_reg #(
        .WIDTH(DATA_W)
    ) u_capture (
        .clk(clk),
        .rst(rst),
        .load(capLoad),
        .d(loadData),
        .q(capValue)
    );

    // Control readback: mode, reserved zeros, fixed feature flags
    assign ctlValue = DATA_W'({stopwatchMode, 3'h0, CTL_FEATURES});
    assign ctlWrite = isWrite && hitCtl;

    // Stopwatch mode; every other bit of every register ignores writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stopwatchMode <= CTL_MODE_RST;
        end
        else if (ctlWrite)
        begin
            stopwatchMode <= req.wdata[CTL_MODE_BIT];
        end
    end

    // First read stage waits for the preset lookup register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdPend <= 1'b0;
            rdSrc <= SRC_NONE;
        end
        else
        begin
            rdPend <= isRead;
            rdSrc <= reqSrc;
        end
    end

    // Read data mux; idle cycles show zero so stale data never lingers
    assign next_rdata = !rdPend ? '0 :
        (rdSrc == SRC_CAPTURE) ? capValue :
        (rdSrc == SRC_CTL) ? ctlValue :
        (rdSrc == SRC_PRIME) ? romData :
        (rdSrc == SRC_SWCTL) ? SWCTL_PRESET : '0;

    // Second stage drives the answer from flops
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata <= '0;
            rdValid <= 1'b0;
        end
        else
        begin
            rdata <= next_rdata;
            rdValid <= rdPend;
        end
    end

    sequence s_ctl_read;
        isRead && hitCtl;
    endsequence

    sequence s_prime_read;
        isRead && (hitPrimeI || hitPrimeD);
    endsequence

    sequence s_answer;
        ##2 rdValid;
    endsequence

    // Mode is one after reset
    property p_mode_reset;
        @(posedge clk)
        rst |=> stopwatchMode;
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("stopwatch mode not one after reset");

    // Write to bit 8 lands in the mode
    property p_mode_write;
        @(posedge clk) disable iff (rst)
        ctlWrite |=> (stopwatchMode == $past(req.wdata[CTL_MODE_BIT]));
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("stopwatch mode write lost");

    // Nothing else moves the mode
    property p_mode_hold;
        @(posedge clk) disable iff (rst)
        !ctlWrite |=> $stable(stopwatchMode);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("stopwatch mode changed without write");

    // Feature flags all read one, reserved bits zero
    property p_ctl_flags;
        @(posedge clk) disable iff (rst)
        s_ctl_read |-> s_answer ##0 (rdata[4:0] == 5'h1f &&
            rdata[7:5] == 3'h0 && rdata[31:9] == 23'h00_0000);
    endproperty
    a_ctl_flags: assert property (p_ctl_flags)
        else $error("control flags or reserved bits wrong");

    // Readback of the mode bit
    property p_ctl_mode_read;
        @(posedge clk) disable iff (rst)
        s_ctl_read |-> s_answer ##0 (rdata[8] == $past(stopwatchMode));
    endproperty
    a_ctl_mode_read: assert property (p_ctl_mode_read)
        else $error("control mode readback wrong");

    // Priming answer has zero condition 0 and zero top bits
    property p_prime_read;
        @(posedge clk) disable iff (rst)
        s_prime_read |-> s_answer ##0 (rdata[7:0] == 8'h00 &&
            rdata[31:30] == 2'h0);
    endproperty
    a_prime_read: assert property (p_prime_read)
        else $error("priming register answer malformed");

    // Stopwatch control always reads its preset
    property p_swctl_read;
        @(posedge clk) disable iff (rst)
        (isRead && hitSwCtl) |-> s_answer ##0 (rdata == SWCTL_PRESET);
    endproperty
    a_swctl_read: assert property (p_swctl_read)
        else $error("stopwatch control not preset");

    // Unmapped reads, including priming B to D, answer zero
    property p_unmapped;
        @(posedge clk) disable iff (rst)
        (isRead && reqSrc == SRC_NONE) |-> s_answer ##0 (rdata == '0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    // Second instruction slot decodes to index one
    property p_stride;
        @(posedge clk) disable iff (rst)
        (COMPLEX_BRK && NUM_IBRK > 1 && req.valid &&
            req.addr == OFS_IBCC + STRIDE_BRK) |->
            (extSel.instCtl && extSel.index == 3'h1);
    endproperty
    a_stride: assert property (p_stride)
        else $error("breakpoint stride decode wrong");

endmodule
`default_nettype wire

// ==== verif/cbr_regs_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module cbr_regs_tb;
    import cbr_pkg::*;

    // Expected priming presets, 8 instruction then 4 data breakpoints
    localparam logic [31:0] PRIME_EXP [0:11] = '{
        32'h1211_2000, 32'h1210_2000, 32'h1413_2100, 32'h1412_2100,
        32'h1615_2200, 32'h1614_2200, 32'h1017_2300, 32'h1016_2300,
        32'h2111_1000, 32'h2213_1200, 32'h2315_1400, 32'h2017_1600
    };
    // Addresses mixed in the random phase, unmapped ones included
    localparam logic [15:0] ADDRS [0:11] = '{
        16'h2ff0, 16'h8000, 16'h8300, 16'h83e0, 16'h84e0, 16'h8540,
        16'h8560, 16'h8900, 16'h8908, 16'h1120, 16'h2430, 16'h0000
    };

    logic clk;
    logic rst;
    cbr_req_t req;
    logic loadBrkTaken;
    logic [DATA_W-1:0] loadData;
    cbr_ext_t extSel;
    logic [DATA_W-1:0] rdata;
    logic rdValid;
    logic stopwatchMode;
    int errCount;
    int totalChecks;
    int cyc = 0;
    int seedVal;
    logic [31:0] capModel;
    logic modeModel;
    logic modeDly = 1'b1;
    logic [31:0] expQ[$];
    int dueQ[$];
    // Second instance without complex break: only the capture answers
    cbr_ext_t extSelP;
    logic [DATA_W-1:0] rdataP;
    logic rdValidP;
    logic modeP;
    logic [31:0] expP[$];

    cbr_regs #(
        .NUM_IBRK(8),
        .NUM_DBRK(4),
        .COMPLEX_BRK(1'b1)
    ) i_dut (
        .clk(clk),
        .rst(rst),
        .req(req),
        .loadBrkTaken(loadBrkTaken),
        .loadData(loadData),
        .extSel(extSel),
        .rdata(rdata),
        .rdValid(rdValid),
        .stopwatchMode(stopwatchMode)
    );

    // Same stimulus, complex break left out of the build
    cbr_regs #(
        .NUM_IBRK(8),
        .NUM_DBRK(4),
        .COMPLEX_BRK(1'b0)
    ) i_dut_plain (
        .clk(clk),
        .rst(rst),
        .req(req),
        .loadBrkTaken(loadBrkTaken),
        .loadData(loadData),
        .extSel(extSelP),
        .rdata(rdataP),
        .rdValid(rdValidP),
        .stopwatchMode(modeP)
    );

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic checkWord(input string name, input logic [31:0] exp,
                             input logic [31:0] got);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic checkBit(input string name, input logic exp,
                            input logic got);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Read model: value a read of this offset must return
    function automatic logic [31:0] expRead(input logic [15:0] a);
        expRead = 32'h0000_0000;
        if (a == 16'h2ff0)
            expRead = capModel;
        if (a == 16'h8000)
            expRead = {23'h00_0000, modeModel, 8'h1f};
        if (a == 16'h8900)
            expRead = 32'h0000_0080;
        for (int n = 0; n < 8; n++)
        begin
            if (a == 16'h8300 + 16'(n * 32))
                expRead = PRIME_EXP[n];
            if (n < 4 && a == 16'h84e0 + 16'(n * 32))
                expRead = PRIME_EXP[8 + n];
        end
    endfunction

    // Decode model of the selects for externally held registers
    function automatic logic [6:0] expExt(input logic [15:0] a);
        expExt = 7'h00;
        for (int n = 0; n < 8; n++)
        begin
            if (a == 16'h1120 + 16'(n * 256))
                expExt = {4'h8, 3'(n)};
            if (a == 16'h1128 + 16'(n * 256))
                expExt = {4'h4, 3'(n)};
            if (n < 4 && a == 16'h2128 + 16'(n * 256))
                expExt = {4'h2, 3'(n)};
            if (n < 4 && a == 16'h2130 + 16'(n * 256))
                expExt = {4'h1, 3'(n)};
        end
    endfunction

    // One access per cycle; the model is updated as the request goes out
    task automatic access(input logic wr, input logic [15:0] addr,
                          input logic [31:0] wd, input logic cap);
        logic [6:0] expSel;
        logic [6:0] gotSel;
        @(posedge clk);
        #1;
        req.valid = 1'b1;
        req.write = wr;
        req.addr = addr;
        req.wdata = wd;
        loadBrkTaken = cap;
        loadData = $urandom;
        if (cap)
            capModel = loadData;
        if (wr && addr == 16'h8000)
            modeModel = wd[8];
        if (!wr)
        begin
            expQ.push_back(expRead(addr));
            // Request edge is the next one; answer stands one edge after it
            dueQ.push_back(cyc + 2);
            expP.push_back((addr == 16'h2ff0) ? capModel : 32'h0000_0000);
        end
        expSel = expExt(addr);
        #1;
        // Index is only meaningful while some select is raised
        gotSel = (expSel[6:3] == 4'h0) ? {extSel[6:3], 3'b000} : extSel;
        checkWord("extSel", {25'h000_0000, expSel},
                  {25'h000_0000, gotSel});
        checkWord("plain extSel", 32'h0000_0000, 32'(extSelP));
    endtask

    // Idle cycles keep the load data moving so a missed strobe shows
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            req.valid = 1'b0;
            loadBrkTaken = 1'b0;
            loadData = $urandom;
        end
    endtask

    task automatic endTest(input string name);
        idle(4);
        $display("test %s done, mismatches so far %0d", name, errCount);
    endtask

    // Cycle count, delayed mode model and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        modeDly <= modeModel;
        if (cyc > 4000)
        begin
            errCount++;
            $display("MISMATCH timeout expected below %0d seen %0d", 4000, cyc);
            tallyAndFinish();
        end
    end

    // Result monitor: every answer, its latency and the quiet cycles
    always @(negedge clk)
    begin
        if (!rst)
        begin
            checkBit("stopwatchMode", modeDly, stopwatchMode);
            checkBit("plain mode", 1'b1, modeP);
            if (rdValid === 1'b1 && expQ.size() > 0)
            begin
                checkWord("rdata", expQ[0], rdata);
                checkWord("latency", dueQ[0], 32'(cyc));
                checkWord("plain rdata", expP[0], rdataP);
                checkBit("plain rdValid", 1'b1, rdValidP);
                void'(expQ.pop_front());
                void'(dueQ.pop_front());
                void'(expP.pop_front());
            end
            else
            begin
                checkBit("rdValid", 1'b0, rdValid);
                checkWord("idle rdata", 32'h0000_0000, rdata);
                checkBit("plain rdValid", 1'b0, rdValidP);
                checkWord("plain idle", 32'h0000_0000, rdataP);
                if (dueQ.size() > 0)
                    checkBit("answer overdue", 1'b1,
                             dueQ[0] >= cyc);
            end
        end
    end

    initial
    begin
        rst = 1'b1;
        req = '0;
        loadBrkTaken = 1'b0;
        loadData = 32'h0000_0000;
        errCount = 0;
        totalChecks = 0;
        modeModel = 1'b1;
        capModel = 'x;
        seedVal = $urandom(54);
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;

        access(1'b0, 16'h8000, 32'h0, 1'b0);
        access(1'b0, 16'h8900, 32'h0, 1'b0);
        access(1'b0, 16'h8908, 32'h0, 1'b0);
        endTest("reset values");

        // Back-to-back captures, two in the same cycle as their reads
        access(1'b0, 16'h2000, 32'h0, 1'b1);
        access(1'b0, 16'h2ff0, 32'h0, 1'b0);
        access(1'b0, 16'h2ff0, 32'h0, 1'b1);
        access(1'b0, 16'h2ff0, 32'h0, 1'b1);
        idle(3);
        access(1'b0, 16'h2ff0, 32'h0, 1'b0);
        endTest("capture");

        // Mode writes, reserved bits set, writes to read-only places
        access(1'b1, 16'h8000, 32'h0000_0000, 1'b0);
        access(1'b0, 16'h8000, 32'h0, 1'b0);
        idle(2);
        access(1'b1, 16'h8000, 32'hffff_ffff, 1'b0);
        access(1'b0, 16'h8000, 32'h0, 1'b0);
        idle(2);
        access(1'b1, 16'h8000, 32'hffff_feff, 1'b0);
        access(1'b1, 16'h8900, 32'hffff_ffff, 1'b0);
        access(1'b1, 16'h8300, 32'hffff_ffff, 1'b0);
        access(1'b1, 16'h2ff0, 32'hffff_ffff, 1'b0);
        access(1'b0, 16'h8000, 32'h0, 1'b0);
        access(1'b0, 16'h8900, 32'h0, 1'b0);
        access(1'b0, 16'h8300, 32'h0, 1'b0);
        access(1'b0, 16'h2ff0, 32'h0, 1'b0);
        endTest("mode and read-only");

        // Every priming register, then B/C/D and misaligned offsets
        for (int n = 0; n < 8; n++)
            access(1'b0, 16'h8300 + 16'(n * 32), 32'h0, 1'b0);
        for (int n = 0; n < 5; n++)
            access(1'b0, 16'h84e0 + 16'(n * 32), 32'h0, 1'b0);
        access(1'b0, 16'h8304, 32'h0, 1'b0);
        access(1'b0, 16'h8308, 32'h0, 1'b0);
        access(1'b0, 16'h8310, 32'h0, 1'b0);
        endTest("priming");

        // Selects for the outside registers, past the data count too
        for (int n = 0; n < 8; n++)
        begin
            access(1'b1, 16'h1120 + 16'(n * 256), $urandom, 1'b0);
            access(1'b0, 16'h1128 + 16'(n * 256), 32'h0, 1'b0);
            access(1'b1, 16'h2128 + 16'(n * 256), $urandom, 1'b0);
            access(1'b0, 16'h2130 + 16'(n * 256), 32'h0, 1'b0);
        end
        endTest("select decode");

        // Random mix; a mode write waits so no read of it is in flight
        for (int i = 0; i < 80; i++)
        begin
            logic [15:0] a;
            logic wr;
            a = ADDRS[$urandom % 12];
            wr = 1'($urandom);
            if (wr && a == 16'h8000)
                idle(2);
            access(wr, a, $urandom, 1'($urandom));
        end
        endTest("random");

        // Second reset with reads in flight and mode cleared
        access(1'b1, 16'h8000, 32'h0000_0000, 1'b0);
        access(1'b0, 16'h8300, 32'h0, 1'b0);
        @(posedge clk);
        #1;
        rst = 1'b1;
        req.valid = 1'b0;
        modeModel = 1'b1;
        expQ.delete();
        dueQ.delete();
        expP.delete();
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        access(1'b0, 16'h8000, 32'h0, 1'b0);
        endTest("mid-run reset");

        tallyAndFinish();
    end

endmodule
`default_nettype wire
